// File: core/frcc_top.sv
`timescale 1ns/10ps
`default_nettype none
module frcc_top
   import frcc_pkg::*;
#(
   parameter int CW = FRCC_CNT_W
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic ext_count_clk,
   input wire logic [FRCC_NCAP-1:0] cap_pins,
   output logic [FRCC_NCMP-1:0] cmp_pins,
   // Interrupt
   output logic irq
);
   logic [CW-1:0] count_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] capctl_reg;
   logic [7:0] lvl_reg;
   logic [7:0] run_reg;
   logic pair_reg;
   logic [FRCC_NIRQ-1:0] ist_reg;
   logic [FRCC_NIRQ-1:0] msk_reg;
   logic [CW-1:0] cmpv_reg [FRCC_NCMP];
   logic [CW-1:0] capv [FRCC_NCAP];
   logic [FRCC_NCAP-1:0] cap_hit;
   logic [6:0] pre_reg;
   logic ext_prev_reg;
   logic tick;
   logic wr;
   logic rd;
   logic [FRCC_NCMP-1:0] match;
   logic ovf_ev;
   logic clr_match;
   frcc_apb_e apb_st_reg;

   // Zero wait states; a read is answered in the access cycle
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr = psel & penable & pwrite & (apb_st_reg == FRCC_ACCESS);
   assign rd = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) apb_st_reg <= FRCC_IDLE;
      else if (psel & ~penable) apb_st_reg <= FRCC_ACCESS;
      else apb_st_reg <= FRCC_IDLE;
   end

   // Count rate: prescaled pclk, or rising edge of external source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_reg <= '0;
      else pre_reg <= pre_reg + 7'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ext_prev_reg <= 1'b0;
      else ext_prev_reg <= ext_count_clk;
   end
   always_comb begin
      if (ctrl_reg[FRCC_B_EXT]) tick = ext_count_clk & ~ext_prev_reg;
      else begin
         case (ctrl_reg[FRCC_B_RATE +: 2])
            2'h0: tick = 1'b1;
            2'h1: tick = (pre_reg[1:0] == 2'(FRCC_DIV1 - 1));
            2'h2: tick = (pre_reg[3:0] == 4'(FRCC_DIV2 - 1));
            2'h3: tick = (pre_reg[5:0] == 6'(FRCC_DIV3 - 1));
            default: tick = 1'b0;
         endcase
      end
   end

   assign clr_match = ctrl_reg[FRCC_B_MODE] && match[0];
   assign ovf_ev = tick && !ctrl_reg[FRCC_B_STOP] && !clr_match
      && (count_reg == {CW{1'b1}});

   // Counter: software write, clear bit, stop, match clear, wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count_reg <= FRCC_CNT_RST;
      else if (wr && paddr == FRCC_A_COUNT) count_reg <= pwdata[CW-1:0];
      else if (wr && paddr == FRCC_A_CTRL && pwdata[FRCC_B_CLR])
         count_reg <= '0;
      else if (clr_match && tick && !ctrl_reg[FRCC_B_STOP])
         count_reg <= '0;
      else if (tick && !ctrl_reg[FRCC_B_STOP])
         count_reg <= count_reg + 1'b1;
   end

   // Control: clear bit self-clears; overflow flag set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctrl_reg <= FRCC_CTRL_RST;
      else begin
         if (wr && paddr == FRCC_A_CTRL) begin
            ctrl_reg <= pwdata[7:0];
            ctrl_reg[FRCC_B_CLR] <= 1'b0;
            ctrl_reg[FRCC_B_OVF] <= ctrl_reg[FRCC_B_OVF]
               & pwdata[FRCC_B_OVF];
         end
         if (ovf_ev) ctrl_reg[FRCC_B_OVF] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) capctl_reg <= '0;
      else if (wr && paddr == FRCC_A_CAPCTL) capctl_reg <= pwdata[7:0];
   end

   genvar g;
   generate
      for (g = 0; g < FRCC_NCAP; g++) begin : g_cap
         // Each channel watches only its own pin
         frcc_capture_chan #(.CW(CW)) u_cap (
            .pclk(pclk),
            .presetn(presetn),
            .cap_pin(cap_pins[g]),
            .edge_sel(capctl_reg[2*g +: 2]),
            .count(count_reg),
            .hit(cap_hit[g]),
            .value_reg(capv[g])
         );
      end
      for (g = 0; g < FRCC_NCMP; g++) begin : g_cmp
         // A held counter must not retrigger the same match every cycle
         assign match[g] = run_reg[g] && count_reg == cmpv_reg[g]
            && tick && !ctrl_reg[FRCC_B_STOP];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) cmpv_reg[g] <= '0;
            else if (wr && paddr == FRCC_A_CMP0 + 12'(4 * g))
               cmpv_reg[g] <= pwdata[CW-1:0];
         end
      end
   endgenerate

   // Compare control and output levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_reg <= '0;
         run_reg <= '0;
         pair_reg <= 1'b0;
      end else if (wr && paddr == FRCC_A_CMPCTL) begin
         lvl_reg <= pwdata[FRCC_B_LVL +: 8];
         run_reg <= pwdata[FRCC_B_RUN +: 8];
         pair_reg <= pwdata[FRCC_B_PAIR];
      end else begin
         for (int i = 0; i < FRCC_NCMP; i += 2) begin
            if (pair_reg) begin
               // Both matches of a pair act on the even pin
               if (match[i] ^ match[i+1]) lvl_reg[i] <= ~lvl_reg[i];
            end else begin
               if (match[i]) lvl_reg[i] <= ~lvl_reg[i];
               if (match[i+1]) lvl_reg[i+1] <= ~lvl_reg[i+1];
            end
         end
      end
   end
   always_comb begin
      cmp_pins = lvl_reg;
      if (pair_reg) begin
         for (int i = 0; i < FRCC_NCMP; i += 2) cmp_pins[i+1] = lvl_reg[i];
      end
   end

   // Sticky flags; software clears by writing one to IRQST, zero to CMPFLG or CAPCTL; a new event wins
   logic [FRCC_NIRQ-1:0] ev;
   assign ev = {match, cap_hit, ovf_ev};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ist_reg <= '0;
      else if (wr && paddr == FRCC_A_IRQST)
         ist_reg <= (ist_reg & ~pwdata[FRCC_NIRQ-1:0]) | ev;
      else if (wr && paddr == FRCC_A_CMPFLG)
         ist_reg <= (ist_reg & {pwdata[7:0], {(FRCC_NIRQ-8){1'b1}}})
            | ev;
      else if (wr && paddr == FRCC_A_CAPCTL)
         ist_reg <= (ist_reg & {{8{1'b1}}, pwdata[7:4], 1'b1}) | ev;
      else ist_reg <= ist_reg | ev;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) msk_reg <= '0;
      else if (wr && paddr == FRCC_A_IRQMSK) msk_reg <= pwdata[FRCC_NIRQ-1:0];
   end
   // Overflow enable also gates the overflow source
   assign irq = |(ist_reg & msk_reg
      & {{(FRCC_NIRQ-1){1'b1}}, ctrl_reg[FRCC_B_OVFE]});

   // Read data registered in setup cycle, valid in access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (rd) begin
         prdata <= '0;
         case (paddr)
            FRCC_A_COUNT: prdata[CW-1:0] <= count_reg;
            FRCC_A_CTRL: prdata[7:0] <= ctrl_reg;
            FRCC_A_CAPCTL: prdata[7:0] <= {ist_reg[FRCC_I_CAP +: 4],
               capctl_reg[3:0]};
            FRCC_A_CMPCTL: prdata[FRCC_B_PAIR:0] <= {pair_reg, run_reg,
               lvl_reg};
            FRCC_A_CMPFLG: prdata[7:0] <= ist_reg[FRCC_I_CMP +: 8];
            FRCC_A_IRQST: prdata[FRCC_NIRQ-1:0] <= ist_reg;
            FRCC_A_IRQMSK: prdata[FRCC_NIRQ-1:0] <= msk_reg;
            FRCC_A_CAP0: prdata[CW-1:0] <= capv[0];
            FRCC_A_CAP0 + 12'h004: prdata[CW-1:0] <= capv[1];
            FRCC_A_CAP0 + 12'h008: prdata[CW-1:0] <= capv[2];
            FRCC_A_CAP0 + 12'h00c: prdata[CW-1:0] <= capv[3];
            default: begin
               for (int i = 0; i < FRCC_NCMP; i++)
                  if (paddr == FRCC_A_CMP0 + 12'(4 * i))
                     prdata[CW-1:0] <= cmpv_reg[i];
            end
         endcase
      end
   end

   a_stop_holds: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl_reg[FRCC_B_STOP] && !wr |=> $stable(count_reg))
      else $error("counter moved while stopped");
   // A register write in the same cycle may load the counter instead
   a_ovf_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      ovf_ev |=> ctrl_reg[FRCC_B_OVF] && (count_reg == '0 || $past(wr)))
      else $error("overflow not flagged");
   a_match_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      clr_match && !wr && !ctrl_reg[FRCC_B_STOP] |=> count_reg == '0)
      else $error("compare 0 did not clear counter");
   a_match_toggle: assert property (
      @(posedge pclk) disable iff (!presetn)
      match[1] && !pair_reg && !wr |=> lvl_reg[1] != $past(lvl_reg[1]))
      else $error("compare output not toggled");
   a_cap_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      |cap_hit |=> (ist_reg[FRCC_I_CAP +: FRCC_NCAP] & $past(cap_hit))
         == $past(cap_hit))
      else $error("capture flag not set");
   // Both run bits off: neither match of the pair may move the even level
   a_run_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !run_reg[2] && !run_reg[3] && !(wr && paddr == FRCC_A_CMPCTL)
      |=> $stable(lvl_reg[2]))
      else $error("output moved while channel stopped");
   a_count_step: assert property (
      @(posedge pclk) disable iff (!presetn)
      tick && !ctrl_reg[FRCC_B_STOP] && !wr && !clr_match
      |=> count_reg == $past(count_reg) + 1'b1)
      else $error("counter did not advance");
   a_pair_pin: assert property (
      @(posedge pclk) disable iff (!presetn)
      pair_reg |-> cmp_pins[1] == cmp_pins[0])
      else $error("pair pins differ");
   a_irq_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      |(ist_reg[FRCC_I_CAP +: FRCC_NCAP] & msk_reg[FRCC_I_CAP +: FRCC_NCAP])
      |-> irq)
      else $error("interrupt missing");
endmodule // frcc_top
`default_nettype wire

// File: core/frcc_pkg.sv
// Overview of operation
// - Sixteen-bit up counter wraps past maximum
// - Two-bit select picks one of four rates
// - Overflow sets flag, interrupt when enabled
// - Mode bit clears counter on channel 0 match
// - Valid capture edge copies counter value
// - Edge select: rising, falling or both
// - Capture edge sets flag, enabled interrupt
// - Each capture channel has own pin
// - Compare match inverts output and sets flag
// - Eight independent compare channels with pins
// - Pair mode: two matches drive one level on both pins of the pair
// - Software presets each compare output level
package frcc_pkg;
   localparam int FRCC_CNT_W = 16;
   localparam int FRCC_NCAP = 4;
   localparam int FRCC_NCMP = 8;
   // Byte addresses of the register words
   localparam logic [11:0] FRCC_A_COUNT = 12'h000;
   localparam logic [11:0] FRCC_A_CTRL = 12'h004;
   localparam logic [11:0] FRCC_A_CAPCTL = 12'h008;
   localparam logic [11:0] FRCC_A_CMPCTL = 12'h00c;
   localparam logic [11:0] FRCC_A_CMPFLG = 12'h010;
   localparam logic [11:0] FRCC_A_IRQST = 12'h014;
   localparam logic [11:0] FRCC_A_IRQMSK = 12'h018;
   localparam logic [11:0] FRCC_A_CAP0 = 12'h040;
   localparam logic [11:0] FRCC_A_CMP0 = 12'h080;
   // Control/status field positions
   localparam int FRCC_B_RATE = 0;
   localparam int FRCC_B_CLR = 2;
   localparam int FRCC_B_MODE = 3;
   localparam int FRCC_B_STOP = 4;
   localparam int FRCC_B_OVFE = 5;
   localparam int FRCC_B_OVF = 6;
   localparam int FRCC_B_EXT = 7;
   // Compare control: levels [7:0], run [15:8], pair bit
   localparam int FRCC_B_LVL = 0;
   localparam int FRCC_B_RUN = 8;
   localparam int FRCC_B_PAIR = 16;
   // Interrupt status bits: overflow, capture, compare
   localparam int FRCC_I_OVF = 0;
   localparam int FRCC_I_CAP = 1;
   localparam int FRCC_I_CMP = 5;
   localparam int FRCC_NIRQ = 13;
   localparam logic [15:0] FRCC_CNT_RST = 16'h0000;
   localparam logic [7:0] FRCC_CTRL_RST = 8'h00;
   // Prescale divisors for rate codes 0..3
   localparam int FRCC_DIV0 = 1;
   localparam int FRCC_DIV1 = 4;
   localparam int FRCC_DIV2 = 16;
   localparam int FRCC_DIV3 = 64;
   localparam logic [1:0] FRCC_EDGE_NONE = 2'h0;
   localparam logic [1:0] FRCC_EDGE_RISE = 2'h1;
   localparam logic [1:0] FRCC_EDGE_FALL = 2'h2;
   localparam logic [1:0] FRCC_EDGE_BOTH = 2'h3;
   typedef enum logic [1:0] {FRCC_IDLE, FRCC_ACCESS} frcc_apb_e;
endpackage

// File: core/frcc_capture_chan.sv
`timescale 1ns/10ps
`default_nettype none
module frcc_capture_chan
   import frcc_pkg::*;
#(
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and selection
   input wire logic cap_pin,
   input wire logic [1:0] edge_sel,
   input wire logic [CW-1:0] count,
   // Result
   output logic hit,
   output logic [CW-1:0] value_reg
);
   logic prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prev_reg <= 1'b0;
      else prev_reg <= cap_pin;
   end
   always_comb begin
      case (edge_sel)
         FRCC_EDGE_RISE: hit = cap_pin & ~prev_reg;
         FRCC_EDGE_FALL: hit = ~cap_pin & prev_reg;
         FRCC_EDGE_BOTH: hit = cap_pin ^ prev_reg;
         default: hit = 1'b0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) value_reg <= '0;
      else if (hit) value_reg <= count;
   end
   a_capture_latch: assert property (
      @(posedge pclk) disable iff (!presetn)
      hit |=> value_reg == $past(count))
      else $error("capture value not latched");
endmodule // frcc_capture_chan
`default_nettype wire

// File: test/frcc_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module frcc_pins_model (
   // Clock
   input wire logic pclk,
   // Pins to and from the unit
   output logic [3:0] cap_pins,
   output logic ext_count_clk,
   input wire logic [7:0] cmp_pins
);
   initial begin
      cap_pins = 4'h0;
      ext_count_clk = 1'b0;
   end
   // Held 4 cycles so the edge detector sees every level
   task automatic set_cap(input int ch, input logic v);
      @(posedge pclk);
      cap_pins[ch] <= v;
      repeat (4) @(posedge pclk);
   endtask
   // Slow source: 3 cycles high, 4 low per tick
   task automatic ext_ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_count_clk <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_count_clk <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
endmodule // frcc_pins_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import frcc_pkg::*;
   localparam logic [31:0] CLR = 32'h1 << FRCC_B_CLR;
   localparam logic [31:0] MODE = 32'h1 << FRCC_B_MODE;
   localparam logic [31:0] STOP = 32'h1 << FRCC_B_STOP;
   localparam logic [31:0] OVFE = 32'h1 << FRCC_B_OVFE;
   localparam logic [31:0] OVF = 32'h1 << FRCC_B_OVF;
   localparam logic [31:0] EXT = 32'h1 << FRCC_B_EXT;
   localparam logic [31:0] PAIR = 32'h1 << FRCC_B_PAIR;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, got;
   logic pready, pslverr, irq, ext_count_clk;
   logic [3:0] cap_pins;
   logic [7:0] cmp_pins;
   logic [31:0] rnd = 32'h72f4;
   logic [31:0] expq[$], mskq[$];
   int n_errors = 0, n_tests = 0;
   int dv[4] = '{FRCC_DIV0, FRCC_DIV1, FRCC_DIV2, FRCC_DIV3};
   always #2.5 pclk = ~pclk;
   frcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_count_clk(ext_count_clk), .cap_pins(cap_pins),
      .cmp_pins(cmp_pins), .irq(irq));
   frcc_pins_model pm (.pclk(pclk), .cap_pins(cap_pins),
      .ext_count_clk(ext_count_clk), .cmp_pins(cmp_pins));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      got = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
      expq.push_back(e & m);
      mskq.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   // Pins are read after the wait, not when the task is entered
   task automatic pin(input string what, input bit is_irq,
                      input logic [31:0] e);
      repeat (2) @(posedge pclk);
      #1 check(what, is_irq ? {31'h0, irq} : {24'h0, cmp_pins}, e);
   endtask
   // Every completed read is matched with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (expq.size() == 0) check("read note", 32'h1, 32'h0);
         else check("read", prdata & mskq.pop_front(), expq.pop_front());
      end
   end
   initial begin
      int k;
      logic [15:0] v;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(FRCC_A_CTRL, 32'h0, 32'hff);
      rd(12'h0fc, 32'h0, 32'hffffffff);
      wr(FRCC_A_CTRL, STOP);
      wr(FRCC_A_COUNT, 32'hfffd);
      rd(FRCC_A_COUNT, 32'hfffd, 32'hffff);
      wr(FRCC_A_CTRL, OVFE);
      repeat (4) @(posedge pclk);
      wr(FRCC_A_CTRL, OVFE | STOP | OVF);
      rd(FRCC_A_CTRL, OVFE | STOP | OVF, 32'hff);
      rd(FRCC_A_COUNT, 32'h0, 32'hff00);
      wr(FRCC_A_IRQMSK, 32'h1);
      pin("irq ovf", 1'b1, 1);
      wr(FRCC_A_IRQST, 32'h1);
      wr(FRCC_A_CTRL, STOP | CLR);
      pin("irq clr", 1'b1, 0);
      rd(FRCC_A_COUNT, 32'h0, 32'hffff);
      for (k = 0; k < 4; k++) begin
         wr(FRCC_A_CTRL, STOP | CLR);
         wr(FRCC_A_CTRL, k << FRCC_B_RATE);
         repeat (256) @(posedge pclk);
         wr(FRCC_A_CTRL, STOP);
         rd(FRCC_A_COUNT, 32'h0, 32'h0);
         check("rate", got >= 256 / dv[k] - 1 && got <= 264 / dv[k] + 1,
               1);
      end
      wr(FRCC_A_CTRL, STOP | CLR);
      wr(FRCC_A_CTRL, EXT);
      pm.ext_ticks(5);
      wr(FRCC_A_CTRL, EXT | STOP);
      rd(FRCC_A_COUNT, 32'h5, 32'hffff);
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         v = rnd[15:0];
         wr(FRCC_A_COUNT, v);
         wr(FRCC_A_CAPCTL, k << (2 * k));
         pm.set_cap(k, 1'b1);
         rd(FRCC_A_CAPCTL, (k << 2 * k) | (k % 2) << (4 + k), 32'hff);
         pm.set_cap(k, 1'b0);
         rd(FRCC_A_CAPCTL, (k << 2 * k) | (k != 0) << (4 + k), 32'hff);
         rd(FRCC_A_CAP0 + 12'(4 * k), k != 0 ? v : 0, 32'hffff);
      end
      wr(FRCC_A_CMPCTL, 32'ha5);
      pin("preset", 1'b0, 32'ha5);
      for (k = 0; k < 8; k++) wr(FRCC_A_CMP0 + 12'(4 * k), 32'h100 + 2 * k);
      wr(FRCC_A_COUNT, 32'hf0);
      wr(FRCC_A_CMPCTL, 32'h7fa5);
      wr(FRCC_A_CTRL, 32'h0);
      repeat (40) @(posedge pclk);
      wr(FRCC_A_CTRL, STOP);
      pin("toggle", 1'b0, 32'hda);
      rd(FRCC_A_CMPFLG, 32'h7f, 32'hff);
      wr(FRCC_A_CMPFLG, 32'h7e);
      rd(FRCC_A_CMPFLG, 32'h7e, 32'hff);
      wr(FRCC_A_CMP0, 32'h10);
      wr(FRCC_A_CMPCTL, 32'h100);
      wr(FRCC_A_COUNT, 32'h0);
      wr(FRCC_A_CTRL, MODE);
      repeat (50) @(posedge pclk);
      wr(FRCC_A_CTRL, STOP | MODE);
      rd(FRCC_A_COUNT, 32'h0, 32'hffe0);
      wr(FRCC_A_CMP0, 32'h20);
      wr(FRCC_A_CMP0 + 12'h4, 32'h30);
      wr(FRCC_A_CMPCTL, PAIR | 32'h300);
      for (k = 0; k < 2; k++) begin
         wr(FRCC_A_COUNT, k != 0 ? 32'h2f : 32'h1f);
         wr(FRCC_A_CTRL, 32'h0);
         wr(FRCC_A_CTRL, STOP);
         pin("pair", 1'b0, k != 0 ? 32'h0 : 32'h3);
      end
      wr(FRCC_A_IRQMSK, 32'h0);
      pin("irq masked", 1'b1, 0);
      wr(FRCC_A_IRQMSK, 32'h1fff);
      pin("irq set", 1'b1, 1);
      wr(FRCC_A_IRQST, 32'h1fff);
      pin("irq cleared", 1'b1, 0);
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
